/* File: rtl/crc_defs.vh */
// Constants for the configurable CRC engine: register map, fields, reset values, AHB-Lite encodings.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one register per aligned word.
`ifndef CRC_DEFS_VH
`define CRC_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CRC_ADDR_W 8
`define CRC_OFS_CTRL 8'h00
`define CRC_OFS_LEN 8'h04
`define CRC_OFS_ACC 8'h08
`define CRC_OFS_POLY 8'h0c
`define CRC_OFS_WORD 8'h10
`define CRC_OFS_SHIFT 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRC_CTRL_GO 0
`define CRC_CTRL_ORDER 1
`define CRC_CTRL_AUG 2
`define CRC_STAT_BUSY 8
`define CRC_STAT_FULL 9
`define CRC_STAT_DONE 10
`define CRC_WLEN_LSB 0
`define CRC_WLEN_MSB 3
`define CRC_POLY_LENGTH_FIELD_LSB 8
`define CRC_POLY_LENGTH_FIELD_MSB 11
`define CRC_LANE0 0
`define CRC_LANE1 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CRC_RST_WORD16 16'h0000
`define CRC_RST_LEN4 4'h0
`define CRC_RST_DATA32 32'h0000_0000

// ----------------------------------------
// AHB-Lite encodings
// ----------------------------------------
`define AHB_HTRANS_XFER 1
`define AHB_HSIZE_BYTE 3'h0
`define AHB_HSIZE_HALF 3'h1
`define AHB_HRESP_OKAY 1'b0

`endif

/* File: rtl/crc_bit_step.v */
// One shift of the CRC accumulator through the polynomial feedback.
// Assumes the caller masks nothing; width comes from the length field.
`timescale 1ns/10ps
`default_nettype none

module crc_bit_step (
    input wire [15:0] acc_in,
    input wire bit_in,
    input wire [15:0] poly_terms_in,
    input wire [3:0] poly_length_field_in,
    output wire [15:0] nxt_acc_out
);

    function [15:0] len_mask;
        input [3:0] last;
        begin
            len_mask = ~(16'hfffe << last);
        end
    endfunction

    wire top_bit;
    wire [15:0] shifted;
    wire [15:0] eff_poly;

    // Top term sits above the accumulator; it only decides the feedback
    assign top_bit = acc_in[poly_length_field_in];
    assign shifted = {acc_in[14:0], bit_in};
    assign eff_poly = {poly_terms_in[15:1], 1'b1};
    // Classic divider form: zeros must follow the data for the true remainder
    assign nxt_acc_out = (shifted ^ (top_bit ? eff_poly : 16'h0000))
        & len_mask(poly_length_field_in);

endmodule // crc_bit_step

`default_nettype wire

/* File: rtl/crc_bit_pick.v */
// Selects the next data bit from the input shifter.
// Assumes the remaining count runs from the word length field down to zero.
`timescale 1ns/10ps
`default_nettype none

module crc_bit_pick (
    input wire [15:0] shift_in,
    input wire [3:0] remain_in,
    input wire [3:0] word_length_field_in,
    input wire bit_order_select_in,
    output wire bit_out
);

    wire [3:0] index;

    // MSb first starts at the top of the configured length
    assign index = bit_order_select_in ? (word_length_field_in - remain_in) : remain_in;
    assign bit_out = shift_in[index];

endmodule // crc_bit_pick

`default_nettype wire

/* File: rtl/crc_engine.v */
// Configurable CRC engine with AHB-Lite register slave and a word port for a memory scanner.
// Assumes one clock, synchronous reset, and that only one data source is used at a time.
//
// What this block does
// - XOR shift register divides; remainder is check
// - Polynomial and seed up to sixteen bits
// - Length field n-1 gives n-bit accumulator
// - Top and bottom polynomial terms forced one
// - Polynomial bit zero reads back as zero
// - Middle terms come from polynomial register bits
// - Words come from software or scanner
// - Only word-length low bits are used
// - Words pass through shifter into accumulator
// - Bit order select picks MSb or LSb first
// - Low-byte write captures whole word pair
// - Accumulator holds check value when done
// - Augmentation appends accumulator-length zero bits
// - Without augmentation stop after last data bit
// - LSb-first augmented result appears bit reversed
// - Known vector gives 0x32D6 or 0x6BA2
// - Done flag set on busy fall; software clears
// - Full clears when another word fits
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "crc_defs.vh"

module crc_engine (
    input wire sys_clk_in,
    input wire srst_in,
    input wire hsel_in,
    input wire [7:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    input wire scan_word_valid_in,
    input wire [15:0] scan_word_in,
    output wire scan_word_ready_out,
    output wire busy_out,
    output wire full_out,
    output wire done_flag_out
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SHIFT = 3'h2;
    localparam [2:0] ST_ZERO = 3'h4;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [3:0] lane_strobes;
        input [2:0] size;
        input [1:0] low;
        begin
            case (size)
                `AHB_HSIZE_BYTE: lane_strobes = 4'h1 << low;
                `AHB_HSIZE_HALF: lane_strobes = low[1] ? 4'hc : 4'h3;
                default: lane_strobes = 4'hf;
            endcase
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = old;
            if (strb[`CRC_LANE0]) begin
                merge16[7:0] = data[7:0];
            end
            if (strb[`CRC_LANE1]) begin
                merge16[15:8] = data[15:8];
            end
        end
    endfunction

    function [15:0] len_mask;
        input [3:0] last;
        begin
            len_mask = ~(16'hfffe << last);
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [31:0] hrdata_ff;
    reg hreadyout_ff;
    reg hresp_ff;
    reg ph_act_ff;
    reg ph_wr_ff;
    reg [7:0] ph_addr_ff;
    reg [3:0] ph_strb_ff;
    reg go_ff;
    reg bit_order_select_ff;
    reg zero_augment_enable_ff;
    reg [3:0] word_length_field_ff;
    reg [3:0] poly_length_field_ff;
    reg [15:0] check_accumulator_ff;
    reg [15:0] polynomial_terms_ff;
    reg [15:0] input_word_pair_ff;
    reg [15:0] input_shifter_ff;
    reg shift_occ_ff;
    reg [15:0] pend_word_ff;
    reg pend_vld_ff;
    reg [3:0] remain_ff;
    reg [3:0] zero_cnt_ff;
    reg [2:0] state_ff;
    reg aug_due_ff;
    reg busy_ff;
    reg full_ff;
    reg done_ff;
    reg scan_rdy_ff;

    reg [15:0] nxt_check_accumulator;
    reg [15:0] nxt_input_word_pair;
    reg [15:0] nxt_input_shifter;
    reg nxt_shift_occ;
    reg [15:0] nxt_pend_word;
    reg nxt_pend_vld;
    reg [3:0] nxt_remain;
    reg [3:0] nxt_zero_cnt;
    reg [2:0] nxt_state;
    reg nxt_aug_due;
    reg nxt_busy;
    reg nxt_done;
    reg step_en;
    reg step_bit;
    reg [15:0] in_word;
    reg in_vld;

    wire addr_take;
    wire wr_now;
    wire data_bit;
    wire [15:0] stepped_acc;
    wire bus_capture;
    wire scan_take;

    // ----------------------------------------
    // Bus slave: one wait state per transfer
    // ----------------------------------------
    assign addr_take = hsel_in & htrans_in[`AHB_HTRANS_XFER] & hready_in;
    assign wr_now = ph_act_ff & ph_wr_ff;

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            ph_act_ff <= 1'b0;
            ph_wr_ff <= 1'b0;
            ph_addr_ff <= 8'h00;
            ph_strb_ff <= 4'h0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= `AHB_HRESP_OKAY;
            hrdata_ff <= `CRC_RST_DATA32;
        end else begin
            ph_act_ff <= addr_take;
            hresp_ff <= `AHB_HRESP_OKAY;
            if (addr_take) begin
                ph_wr_ff <= hwrite_in;
                ph_addr_ff <= haddr_in;
                ph_strb_ff <= lane_strobes(hsize_in, haddr_in[1:0]);
                hreadyout_ff <= 1'b0;
            end else if (ph_act_ff) begin
                hreadyout_ff <= 1'b1;
            end
            if (ph_act_ff && !ph_wr_ff) begin
                case (ph_addr_ff)
                    `CRC_OFS_CTRL: hrdata_ff <= {21'h000000, done_ff, full_ff, busy_ff, 5'h00,
                        zero_augment_enable_ff, bit_order_select_ff, go_ff};
                    `CRC_OFS_LEN: hrdata_ff <= {20'h00000, poly_length_field_ff, 4'h0, word_length_field_ff};
                    `CRC_OFS_ACC: hrdata_ff <= {16'h0000, check_accumulator_ff};
                    `CRC_OFS_POLY: hrdata_ff <= {16'h0000, polynomial_terms_ff[15:1], 1'b0};
                    `CRC_OFS_WORD: hrdata_ff <= {16'h0000, input_word_pair_ff};
                    `CRC_OFS_SHIFT: hrdata_ff <= {16'h0000, input_shifter_ff};
                    default: hrdata_ff <= `CRC_RST_DATA32;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            go_ff <= 1'b0;
            bit_order_select_ff <= 1'b0;
            zero_augment_enable_ff <= 1'b0;
            word_length_field_ff <= `CRC_RST_LEN4;
            poly_length_field_ff <= `CRC_RST_LEN4;
            polynomial_terms_ff <= `CRC_RST_WORD16;
        end else if (wr_now) begin
            if (ph_addr_ff == `CRC_OFS_CTRL && ph_strb_ff[`CRC_LANE0]) begin
                go_ff <= hwdata_in[`CRC_CTRL_GO];
                bit_order_select_ff <= hwdata_in[`CRC_CTRL_ORDER];
                zero_augment_enable_ff <= hwdata_in[`CRC_CTRL_AUG];
            end
            if (ph_addr_ff == `CRC_OFS_LEN && ph_strb_ff[`CRC_LANE0]) begin
                word_length_field_ff <= hwdata_in[`CRC_WLEN_MSB:`CRC_WLEN_LSB];
            end
            if (ph_addr_ff == `CRC_OFS_LEN && ph_strb_ff[`CRC_LANE1]) begin
                poly_length_field_ff <= hwdata_in[`CRC_POLY_LENGTH_FIELD_MSB:`CRC_POLY_LENGTH_FIELD_LSB];
            end
            if (ph_addr_ff == `CRC_OFS_POLY) begin
                // Bit zero is never stored; hardware supplies the term
                polynomial_terms_ff <= merge16(polynomial_terms_ff, hwdata_in, ph_strb_ff) & 16'hfffe;
            end
        end
    end

    // ----------------------------------------
    // Word entry
    // ----------------------------------------
    // Scanner wins a same-cycle clash; the software word stays in the pair unqueued
    assign scan_take = scan_word_valid_in & scan_rdy_ff;
    assign bus_capture = wr_now & (ph_addr_ff == `CRC_OFS_WORD) & ph_strb_ff[`CRC_LANE0];

    always @* begin
        nxt_input_word_pair = input_word_pair_ff;
        if (wr_now && ph_addr_ff == `CRC_OFS_WORD) begin
            nxt_input_word_pair = merge16(input_word_pair_ff, hwdata_in, ph_strb_ff);
        end
        in_vld = scan_take | bus_capture;
        in_word = (scan_take ? scan_word_in : nxt_input_word_pair)
            & len_mask(word_length_field_ff);
    end

    // ----------------------------------------
    // Shift datapath
    // ----------------------------------------
    crc_bit_pick u_pick (
        .shift_in(input_shifter_ff),
        .remain_in(remain_ff),
        .word_length_field_in(word_length_field_ff),
        .bit_order_select_in(bit_order_select_ff),
        .bit_out(data_bit)
    );

    crc_bit_step u_step (
        .acc_in(check_accumulator_ff),
        .bit_in(step_bit),
        .poly_terms_in(polynomial_terms_ff),
        .poly_length_field_in(poly_length_field_ff),
        .nxt_acc_out(stepped_acc)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_input_shifter = input_shifter_ff;
        nxt_shift_occ = shift_occ_ff;
        nxt_pend_word = pend_word_ff;
        nxt_pend_vld = pend_vld_ff;
        nxt_remain = remain_ff;
        nxt_zero_cnt = zero_cnt_ff;
        nxt_aug_due = aug_due_ff;
        step_en = 1'b0;
        step_bit = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (shift_occ_ff && go_ff) begin
                    nxt_state = ST_SHIFT;
                end else if (aug_due_ff && !go_ff && !shift_occ_ff) begin
                    // Zeros follow the last word once software drops go
                    nxt_state = ST_ZERO;
                    nxt_zero_cnt = poly_length_field_ff;
                    nxt_aug_due = 1'b0;
                end
            end
            ST_SHIFT: begin
                if (go_ff) begin
                    step_en = 1'b1;
                    step_bit = data_bit;
                    if (remain_ff == 4'h0) begin
                        if (pend_vld_ff) begin
                            nxt_input_shifter = pend_word_ff;
                            nxt_remain = word_length_field_ff;
                            nxt_pend_vld = 1'b0;
                        end else begin
                            nxt_shift_occ = 1'b0;
                            nxt_state = ST_IDLE;
                        end
                    end else begin
                        nxt_remain = remain_ff - 4'h1;
                    end
                end
            end
            ST_ZERO: begin
                step_en = 1'b1;
                step_bit = 1'b0;
                if (zero_cnt_ff == 4'h0) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_zero_cnt = zero_cnt_ff - 4'h1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (in_vld) begin
            nxt_aug_due = zero_augment_enable_ff;
            if (!nxt_shift_occ) begin
                nxt_input_shifter = in_word;
                nxt_shift_occ = 1'b1;
                nxt_remain = word_length_field_ff;
            end else begin
                // A writer ignoring full overwrites the pending word
                nxt_pend_word = in_word;
                nxt_pend_vld = 1'b1;
            end
        end
        nxt_busy = nxt_shift_occ | (nxt_state != ST_IDLE);
    end

    // Seed writes win over a shift in the same cycle
    always @* begin
        nxt_check_accumulator = step_en ? stepped_acc : check_accumulator_ff;
        if (wr_now && ph_addr_ff == `CRC_OFS_ACC) begin
            nxt_check_accumulator = merge16(check_accumulator_ff, hwdata_in, ph_strb_ff);
        end
        nxt_done = done_ff;
        if (wr_now && ph_addr_ff == `CRC_OFS_CTRL && ph_strb_ff[`CRC_LANE1] && hwdata_in[`CRC_STAT_DONE]) begin
            nxt_done = 1'b0;
        end
        if (busy_ff && !nxt_busy) begin
            nxt_done = 1'b1;
        end
    end

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_ff <= ST_IDLE;
            check_accumulator_ff <= `CRC_RST_WORD16;
            input_word_pair_ff <= `CRC_RST_WORD16;
            input_shifter_ff <= `CRC_RST_WORD16;
            shift_occ_ff <= 1'b0;
            pend_word_ff <= `CRC_RST_WORD16;
            pend_vld_ff <= 1'b0;
            remain_ff <= `CRC_RST_LEN4;
            zero_cnt_ff <= `CRC_RST_LEN4;
            aug_due_ff <= 1'b0;
            busy_ff <= 1'b0;
            full_ff <= 1'b0;
            done_ff <= 1'b0;
            scan_rdy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            check_accumulator_ff <= nxt_check_accumulator;
            input_word_pair_ff <= nxt_input_word_pair;
            input_shifter_ff <= nxt_input_shifter;
            shift_occ_ff <= nxt_shift_occ;
            pend_word_ff <= nxt_pend_word;
            pend_vld_ff <= nxt_pend_vld;
            remain_ff <= nxt_remain;
            zero_cnt_ff <= nxt_zero_cnt;
            aug_due_ff <= nxt_aug_due;
            busy_ff <= nxt_busy;
            full_ff <= nxt_pend_vld;
            done_ff <= nxt_done;
            scan_rdy_ff <= ~nxt_pend_vld;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hrdata_out = hrdata_ff;
    assign hreadyout_out = hreadyout_ff;
    assign hresp_out = hresp_ff;
    assign scan_word_ready_out = scan_rdy_ff;
    assign busy_out = busy_ff;
    assign full_out = full_ff;
    assign done_flag_out = done_ff;

endmodule // crc_engine

`default_nettype wire

/* File: bench/crc_engine_props.sv */
// Port-level checks on the CRC engine, bound into every instance.
// Assumes hready_in is looped back from the engine's own hreadyout_out.
`timescale 1ns/10ps
`default_nettype none
`include "crc_defs.vh"

module crc_engine_props (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic scan_word_valid_in,
    input wire logic [15:0] scan_word_in,
    input wire logic scan_word_ready_out,
    input wire logic busy_out,
    input wire logic full_out,
    input wire logic done_flag_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    // ----------------------------------------
    // Bus steps
    // ----------------------------------------
    sequence bus_take;
        hsel_in && htrans_in[`AHB_HTRANS_XFER] && hready_in;
    endsequence
    sequence one_wait;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    sequence word_write;
        bus_take ##0 (hwrite_in && haddr_in == `CRC_OFS_WORD);
    endsequence
    sequence poly_read;
        bus_take ##0 (!hwrite_in && haddr_in == `CRC_OFS_POLY);
    endsequence

    chk_bus_wait: assert property (bus_take |=> one_wait)
        else $error("bus answer not after one wait state");
    chk_resp_okay: assert property (hresp_out == `AHB_HRESP_OKAY)
        else $error("bus response not okay");
    chk_poly_bit0: assert property (poly_read |-> ##2 (hreadyout_out && !hrdata_out[0]))
        else $error("polynomial bit zero read as one");
    chk_word_capture: assert property (word_write |-> ##[2:4] busy_out)
        else $error("word write did not make the engine busy");
    chk_scan_capture: assert property (scan_word_valid_in && scan_word_ready_out |-> ##[1:3] busy_out)
        else $error("scanner word did not make the engine busy");
    chk_done_on_fall: assert property ($fell(busy_out) |-> done_flag_out)
        else $error("done flag missing after busy fell");
    chk_done_cause: assert property ($rose(done_flag_out) |-> $fell(busy_out))
        else $error("done flag rose without busy falling");
    chk_done_clear: assert property ($fell(done_flag_out) |-> $past(hwdata_in[`CRC_STAT_DONE]) && !$past(hreadyout_out))
        else $error("done flag cleared without a bus write");
    chk_full_busy: assert property (full_out |-> busy_out)
        else $error("pending word while shifter idle");
endmodule // crc_engine_props

bind crc_engine crc_engine_props crc_engine_props_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .scan_word_valid_in(scan_word_valid_in),
    .scan_word_in(scan_word_in), .scan_word_ready_out(scan_word_ready_out), .busy_out(busy_out),
    .full_out(full_out), .done_flag_out(done_flag_out));
`default_nettype wire

/* File: bench/scan_feeder.sv */
// Memory scanner stand-in: offers words on the engine's scan handshake.
// Assumes the engine takes a word at an edge where valid and ready are high.
`timescale 1ns/10ps
`default_nettype none

module scan_feeder (
    input wire logic clk_in,
    input wire logic scan_word_ready_in,
    output logic scan_word_valid_out,
    output logic [15:0] scan_word_out
);
    // Offers that ran out of time; the bench turns any into a mismatch
    int misses = 0;

    initial begin
        scan_word_valid_out = 1'b0;
        scan_word_out = 16'h0000;
    end

    // Gap of at least one idle cycle keeps one assignment per time step
    task automatic send(input logic [15:0] w, input int gap);
        logic t;
        repeat (gap) @(posedge clk_in);
        scan_word_valid_out <= 1'b1;
        scan_word_out <= w;
        for (int n = 0; n < 200; n++) begin
            @(negedge clk_in);
            t = scan_word_ready_in;
            @(posedge clk_in);
            if (t) break;
        end
        if (!t) misses++;
        // Stale word is inverted so nothing leans on old data
        scan_word_valid_out <= 1'b0;
        scan_word_out <= ~w;
    endtask
endmodule // scan_feeder
`default_nettype wire

/* File: bench/configurable_crc_engine_test.sv */
// Self-checking bench for the CRC engine over AHB-Lite and the scan port.
// Assumes scan_feeder and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`include "crc_defs.vh"

module configurable_crc_engine_test;
    logic sys_clk_in = 1'b0, srst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rdat;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, swv, swr, busy, full, done;
    wire logic [15:0] sw;
    int err_count = 0, compares = 0;

    always #2 sys_clk_in = ~sys_clk_in;

    crc_engine crc_engine_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .scan_word_valid_in(swv),
        .scan_word_in(sw), .scan_word_ready_out(swr), .busy_out(busy), .full_out(full), .done_flag_out(done));
    scan_feeder scan_feeder_inst (.clk_in(sys_clk_in), .scan_word_ready_in(swr), .scan_word_valid_out(swv),
        .scan_word_out(sw));

    // ----------------------------------------
    // Reporting and waits
    // ----------------------------------------
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic fail_wait(input string what);
        err_count++;
        $display("mismatch %s expected answer seen timeout", what);
        give_verdict();
    endtask
    // Signals sampled at the falling edge, clear of the launching edge
    task automatic wait_ready;
        logic t;
        for (int n = 0; n < 100; n++) begin
            @(negedge sys_clk_in);
            t = hready;
            rdat = hrdata;
            @(posedge sys_clk_in);
            if (t) return;
        end
        fail_wait("hready");
    endtask
    // sel 0 busy low, 1 full low, 2 done high
    task automatic wait_for(input int sel, output int cyc);
        for (cyc = 0; cyc < 3000; cyc++) begin
            @(negedge sys_clk_in);
            if ((sel == 0 && busy === 1'b0) || (sel == 1 && full === 1'b0) || (sel == 2 && done === 1'b1)) return;
        end
        fail_wait("engine");
    endtask

    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk_in);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(a, 1'b0, 32'h0);
        chk(what, exp, rdat);
    endtask

    // Reference divider: shift left, data into bit 0, feedback from top bit
    function automatic logic [15:0] crc_ref(input logic [15:0] acc, d, input int nb, n,
        input logic [15:0] p, input logic lsb);
        logic fb;
        for (int i = 0; i < nb; i++) begin
            fb = acc[n-1];
            acc = {acc[14:0], lsb ? d[i] : d[nb-1-i]};
            if (fb) acc = acc ^ (p | 16'h0001);
            acc = acc & ((16'h1 << n) - 16'h1);
        end
        return acc;
    endfunction

    task automatic setup(input logic [31:0] poly, len, seed, ctrl);
        wr(`CRC_OFS_POLY, poly);
        wr(`CRC_OFS_LEN, len);
        wr(`CRC_OFS_ACC, seed);
        wr(`CRC_OFS_CTRL, ctrl);
    endtask
    // Data first drains with go set; dropping go then starts the zeros
    task automatic finish_run(input string what, input logic [31:0] ctrl, exp);
        int c;
        @(posedge sys_clk_in);
        wait_for(0, c);
        if (ctrl[2]) begin
            wr(`CRC_OFS_CTRL, ctrl | 32'h400);
            wait_for(2, c);
        end
        rd_chk(what, `CRC_OFS_ACC, exp);
        chk("done", 32'h1, {31'h0, done});
        wr(`CRC_OFS_CTRL, 32'h400);
        chk("done cleared", 32'h0, {31'h0, done});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd_chk("ctrl", `CRC_OFS_CTRL, 32'h0);
        rd_chk("len", `CRC_OFS_LEN, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd_chk("unmapped", 8'h40, 32'h0);
        wr(`CRC_OFS_POLY, 32'h8005);
        rd_chk("poly", `CRC_OFS_POLY, 32'h8004);
        wr(`CRC_OFS_ACC, 32'hbeef);
        rd_chk("seed", `CRC_OFS_ACC, 32'hbeef);
        chk("resp", 32'h0, {31'h0, hresp});
        $display("test registers done");
    endtask
    task automatic t_vector(input logic lsb, input logic [31:0] exp);
        logic [7:0] b[4] = '{8'h55, 8'h66, 8'h77, 8'h88};
        int c;
        setup(32'h8004, 32'h0f07, 32'h0, {29'h0, 1'b1, lsb, 1'b1});
        foreach (b[i]) begin
            wait_for(1, c);
            wr(`CRC_OFS_WORD, {24'hab_cdef, b[i]});
            @(negedge sys_clk_in);
            if (i == 1) chk("full", 32'h1, {31'h0, full});
        end
        finish_run("vector", {29'h0, 1'b1, lsb, 1'b0}, exp);
        $display("test vector order %0d done", lsb);
    endtask
    task automatic t_scan;
        setup(32'h8004, 32'h0f07, 32'h0, 32'h5);
        scan_feeder_inst.send(16'hff55, 1);
        scan_feeder_inst.send(16'h0066, 6);
        scan_feeder_inst.send(16'h1277, 1);
        scan_feeder_inst.send(16'h0088, 3);
        if (scan_feeder_inst.misses != 0) fail_wait("scan ready");
        finish_run("scan vector", 32'h4, 32'h32d6);
        $display("test scanner done");
    endtask
    task automatic t_noaug;
        logic [15:0] e;
        int c;
        e = crc_ref(16'hff, 16'habc, 12, 8, 16'h07, 1'b0);
        setup(32'h06, 32'h070b, 32'hff, 32'h1);
        wr(`CRC_OFS_WORD, 32'hfabc);
        wait_for(0, c);
        chk("shift cycles", 32'h1, {31'h0, c >= 11 && c <= 14});
        rd_chk("no zeros", `CRC_OFS_ACC, {16'h0, e});
        wr(`CRC_OFS_LEN, 32'h0707);
        wr(`CRC_OFS_WORD, 32'h0);
        finish_run("user zeros", 32'h1, {16'h0, crc_ref(e, 16'h0, 8, 8, 16'h07, 1'b0)});
        // Feeding the check value itself after the data leaves zero
        setup(32'h06, 32'h0707, {16'h0, e}, 32'h1);
        wr(`CRC_OFS_WORD, {16'h0, crc_ref(e, 16'h0, 8, 8, 16'h07, 1'b0)});
        finish_run("check fed", 32'h1, 32'h0);
        $display("test no augmentation done");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        t_regs();
        t_vector(1'b0, 32'h32d6);
        t_vector(1'b1, 32'h6ba2);
        t_scan();
        t_noaug();
        give_verdict();
    end
endmodule // configurable_crc_engine_test
`default_nettype wire
